// >>> core/dtc_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_buffer
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire dtc_pkg::dtc_line_t wr_line,
  input wire logic [dtc_pkg::PTR_W-1:0] rd_idx,
  output dtc_pkg::dtc_line_t rd_line,
  output logic [dtc_pkg::PTR_W-1:0] wr_ptr,
  output logic wrapped
);

  dtc_pkg::dtc_line_t mem_r [dtc_pkg::DEPTH];
  logic [dtc_pkg::PTR_W-1:0] ptr_r;
  logic wrap_r;
  dtc_pkg::dtc_line_t rd_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ptr_r <= '0;
      wrap_r <= 1'b0;
    end
    else if (wr_en)
    begin
      mem_r[ptr_r] <= wr_line;
      ptr_r <= ptr_r + 1'b1;
      if (&ptr_r)
      begin
        wrap_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_r <= '0;
    end
    else
    begin
      rd_r <= mem_r[rd_idx];
    end
  end

  assign rd_line = rd_r;
  assign wr_ptr = ptr_r;
  assign wrapped = wrap_r;

endmodule
`default_nettype wire

// >>> core/dtc_capture.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_capture
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic trace_enable,
  input wire dtc_pkg::dtc_mode_t mode,
  input wire dtc_pkg::dtc_src_t trace_src,
  input wire logic [1:0] trace_range_select,
  input wire logic [dtc_pkg::ADDR_W-1:0] comp_c_addr,
  input wire logic [dtc_pkg::ADDR_W-1:0] comp_d_addr,
  input wire dtc_pkg::dtc_main_bus_t main_bus,
  input wire dtc_pkg::dtc_copro_bus_t copro_bus,
  input wire logic [dtc_pkg::PTR_W-1:0] rd_idx,
  output dtc_pkg::dtc_line_t rd_line,
  output logic [dtc_pkg::PTR_W-1:0] wr_ptr,
  output logic wrapped,
  output logic entry_stb,
  output logic dropped_stb
);

  // Splits an address and builds the info byte
  function automatic dtc_pkg::dtc_line_t make_line
  (
    input logic [dtc_pkg::ADDR_W-1:0] a,
    input logic src,
    input logic wr,
    input logic wd,
    input logic [1:0] cof_k,
    input logic [1:0] cx,
    input logic [dtc_pkg::DATA_W-1:0] d,
    input logic [dtc_pkg::ADDR_W-1:0] spc
  );
    dtc_pkg::dtc_line_t l;
    l = '0;
    l.addr_high_byte = a[dtc_pkg::ADDR_HI_LSB +: dtc_pkg::BYTE_W];
    l.addr_mid_byte = a[dtc_pkg::ADDR_MID_LSB +: dtc_pkg::BYTE_W];
    l.addr_low_byte = a[dtc_pkg::ADDR_LO_LSB +: dtc_pkg::BYTE_W];
    l.info_byte[dtc_pkg::INF_SRC_BIT] = src;
    l.info_byte[dtc_pkg::INF_RW_BIT] = wr;
    l.info_byte[dtc_pkg::INF_SZ_BIT] = wd;
    l.info_byte[dtc_pkg::INF_COF_LSB +: 2] = cof_k;
    l.info_byte[dtc_pkg::INF_CX_LSB +: 2] = cx;
    l.data = d;
    l.snap_pc = spc;
    return l;
  endfunction

  wire logic mode_cof;
  wire logic mode_loop;
  wire logic mode_detail;
  wire logic mode_pc;
  wire logic use_main;
  wire logic use_copro;
  wire logic main_only;
  wire logic in_range;
  wire logic main_det_ok;
  wire logic copro_det_ok;
  wire logic main_cand;
  wire logic copro_cand;
  wire logic pick_main;
  wire logic cand_valid;
  wire logic cand_source;
  wire logic drop;
  wire logic store;
  wire logic [1:0] cx_code;
  wire logic [dtc_pkg::ADDR_W-1:0] cand_addr;
  dtc_pkg::dtc_line_t main_line;
  dtc_pkg::dtc_line_t copro_line;
  dtc_pkg::dtc_line_t cand_line;
  logic copro_pend_r;
  logic copro_pend_nxt;
  dtc_pkg::dtc_copro_bus_t copro_hold_r;
  dtc_pkg::dtc_copro_bus_t copro_sel;
  logic entry_r;
  logic dropped_r;

  assign mode_loop = (mode == dtc_pkg::DTC_MODE_LOOP);
  assign mode_cof = (mode == dtc_pkg::DTC_MODE_NORMAL) || mode_loop;
  assign mode_detail = (mode == dtc_pkg::DTC_MODE_DETAIL);
  assign mode_pc = (mode == dtc_pkg::DTC_MODE_PURE_PC);
  assign use_main = (trace_src != dtc_pkg::DTC_SRC_COPRO);
  assign use_copro = (trace_src != dtc_pkg::DTC_SRC_MAIN);
  assign main_only = (trace_src == dtc_pkg::DTC_SRC_MAIN);

  assign in_range = (main_bus.addr >= comp_c_addr) && (main_bus.addr <= comp_d_addr);

  assign main_det_ok = (main_bus.cyc != dtc_pkg::DTC_CYC_FREE)
    && (main_bus.cyc != dtc_pkg::DTC_CYC_OPFETCH)
    && (!main_only || (trace_range_select != dtc_pkg::RANGE_INSIDE) || in_range);

  assign copro_det_ok = copro_sel.load_store && !copro_sel.vec_gpr_init;

  assign main_cand = trace_enable && use_main && main_bus.valid
    && ((mode_cof && main_bus.change_of_flow) || (mode_detail && main_det_ok)
    || (mode_pc && main_bus.opcode_exec));

  assign copro_cand = trace_enable && use_copro && copro_sel.valid
    && ((mode_cof && copro_sel.change_of_flow) || (mode_detail && copro_det_ok)
    || (mode_pc && copro_sel.opcode_exec));

  // Main has priority, coprocessor event held until a cycle without a main candidate
  assign pick_main = main_cand;
  assign cand_valid = main_cand || copro_cand;

  always_comb
  begin
    copro_sel = copro_pend_r ? copro_hold_r : copro_bus;
    copro_pend_nxt = 1'b0;
    if (main_cand && copro_cand)
    begin
      copro_pend_nxt = 1'b1;
    end
  end

  assign cx_code = !copro_bus.active ? dtc_pkg::CX_IDLE
    : !copro_bus.load_store ? dtc_pkg::CX_RUN
    : copro_bus.write ? dtc_pkg::CX_STORE : dtc_pkg::CX_LOAD;

  always_comb
  begin
    main_line = '0;
    copro_line = '0;
    if (mode_detail)
    begin
      main_line = make_line(main_bus.addr, dtc_pkg::INF_SRC_MAIN, main_bus.write,
        main_bus.word, 2'h0, cx_code, main_bus.data, copro_bus.pc);
      copro_line = make_line(copro_sel.addr, dtc_pkg::INF_SRC_COPRO, copro_sel.write,
        copro_sel.word, 2'h0, 2'h0, copro_sel.data, main_bus.pc);
    end
    else
    begin
      main_line = make_line(main_bus.addr, dtc_pkg::INF_SRC_MAIN, 1'b0, 1'b0,
        main_bus.cof_kind, 2'h0, '0, '0);
      copro_line = make_line(copro_sel.addr, dtc_pkg::INF_SRC_COPRO, 1'b0, 1'b0,
        copro_sel.cof_kind, 2'h0, '0, '0);
    end
  end

  assign cand_line = pick_main ? main_line : copro_line;
  assign cand_addr = pick_main ? main_bus.addr : copro_sel.addr;
  assign cand_source = pick_main ? (main_bus.cof_kind == dtc_pkg::DTC_COF_SOURCE)
    : (copro_sel.cof_kind == dtc_pkg::DTC_COF_SOURCE);

  dtc_loop_filter u_filter
  (
    .clk(clk),
    .rst_n(rst_n),
    .enable(mode_loop),
    .cand_valid(cand_valid),
    .is_source(cand_source),
    .cand_addr(cand_addr),
    .stored(store),
    .drop(drop)
  );

  assign store = cand_valid && !drop;

  dtc_buffer u_buf
  (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(store),
    .wr_line(cand_line),
    .rd_idx(rd_idx),
    .rd_line(rd_line),
    .wr_ptr(wr_ptr),
    .wrapped(wrapped)
  );

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      copro_pend_r <= 1'b0;
      copro_hold_r <= '0;
      entry_r <= 1'b0;
      dropped_r <= 1'b0;
    end
    else
    begin
      copro_pend_r <= copro_pend_nxt;
      copro_hold_r <= copro_sel;
      entry_r <= store;
      dropped_r <= cand_valid && drop;
    end
  end

  assign entry_stb = entry_r;
  assign dropped_stb = dropped_r;

endmodule
`default_nettype wire

// >>> core/dtc_loop_filter.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_loop_filter
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic cand_valid,
  input wire logic is_source,
  input wire logic [dtc_pkg::ADDR_W-1:0] cand_addr,
  input wire logic stored,
  output logic drop
);

  logic [dtc_pkg::ADDR_W-1:0] hold_r;
  logic hold_vld_r;
  wire logic match;

  assign match = hold_vld_r && (hold_r == cand_addr);
  assign drop = enable && cand_valid && is_source && match;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hold_r <= '0;
      hold_vld_r <= 1'b0;
    end
    else if (stored)
    begin
      hold_r <= cand_addr;
      hold_vld_r <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> core/dtc_pkg.sv
package dtc_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int DEPTH = 64;
  localparam int PTR_W = 6;

  // Trace modes
  typedef enum logic [1:0]
  {
    DTC_MODE_NORMAL = 2'h0,
    DTC_MODE_LOOP = 2'h1,
    DTC_MODE_DETAIL = 2'h2,
    DTC_MODE_PURE_PC = 2'h3
  } dtc_mode_t;

  // Traced source select
  typedef enum logic [1:0]
  {
    DTC_SRC_BOTH = 2'h0,
    DTC_SRC_COPRO = 2'h1,
    DTC_SRC_MAIN = 2'h2
  } dtc_src_t;

  // Change-of-flow entry kinds
  typedef enum logic [1:0]
  {
    DTC_COF_SOURCE = 2'h0,
    DTC_COF_DEST = 2'h1,
    DTC_COF_VECTOR = 2'h2
  } dtc_cof_t;

  // Main processor bus cycle kinds
  typedef enum logic [2:0]
  {
    DTC_CYC_FREE = 3'h0,
    DTC_CYC_OPFETCH = 3'h1,
    DTC_CYC_READ = 3'h2,
    DTC_CYC_WRITE = 3'h3,
    DTC_CYC_VECTOR = 3'h4
  } dtc_cyc_t;

  // Info byte bit positions
  localparam int INF_RW_BIT = 0;
  localparam int INF_SZ_BIT = 1;
  localparam int INF_COF_LSB = 2;
  localparam int INF_CX_LSB = 4;
  localparam int INF_SRC_BIT = 7;

  // Address byte positions within a 24-bit address
  localparam int ADDR_HI_LSB = 16;
  localparam int ADDR_MID_LSB = 8;
  localparam int ADDR_LO_LSB = 0;
  localparam int BYTE_W = 8;

  localparam logic INF_SRC_MAIN = 1'b0;
  localparam logic INF_SRC_COPRO = 1'b1;

  // Range select codes
  localparam logic [1:0] RANGE_OFF = 2'h0;
  localparam logic [1:0] RANGE_INSIDE = 2'h3;

  // Coprocessor activity codes
  localparam logic [1:0] CX_IDLE = 2'h0;
  localparam logic [1:0] CX_RUN = 2'h1;
  localparam logic [1:0] CX_LOAD = 2'h2;
  localparam logic [1:0] CX_STORE = 2'h3;

  typedef struct packed
  {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic write;
    logic word;
    dtc_cyc_t cyc;
    dtc_cof_t cof_kind;
    logic change_of_flow;
    logic opcode_exec;
    logic [ADDR_W-1:0] pc;
  } dtc_main_bus_t;

  typedef struct packed
  {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic write;
    logic word;
    logic load_store;
    logic vec_gpr_init;
    dtc_cof_t cof_kind;
    logic change_of_flow;
    logic opcode_exec;
    logic active;
    logic [ADDR_W-1:0] pc;
  } dtc_copro_bus_t;

  // One trace buffer line
  typedef struct packed
  {
    logic [7:0] addr_high_byte;
    logic [7:0] addr_mid_byte;
    logic [7:0] addr_low_byte;
    logic [7:0] info_byte;
    logic [DATA_W-1:0] data;
    logic [ADDR_W-1:0] snap_pc;
  } dtc_line_t;

endpackage

// >>> verif/dtc_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_bus_model
(
  input wire logic clk,
  output var dtc_pkg::dtc_main_bus_t main_bus,
  output var dtc_pkg::dtc_copro_bus_t copro_bus
);
  localparam int MW = $bits(dtc_pkg::dtc_main_bus_t);
  localparam int CW = $bits(dtc_pkg::dtc_copro_bus_t);
  initial
  begin
    main_bus = '0;
    copro_bus = '0;
  end
  // One event per cycle, idle lines show inverted junk
  task automatic send(input dtc_pkg::dtc_main_bus_t m, input dtc_pkg::dtc_copro_bus_t c);
    @(posedge clk);
    main_bus <= m.valid ? m : {1'b0, ~main_bus[MW-2:0]};
    copro_bus <= c.valid ? c : {1'b0, ~copro_bus[CW-2:0]};
  endtask
endmodule
`default_nettype wire

// >>> verif/dtc_capture_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_capture_checker
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic trace_enable,
  input wire dtc_pkg::dtc_mode_t mode,
  input wire dtc_pkg::dtc_main_bus_t main_bus,
  input wire dtc_pkg::dtc_copro_bus_t copro_bus,
  input wire logic [dtc_pkg::PTR_W-1:0] wr_ptr,
  input wire logic wrapped,
  input wire logic entry_stb,
  input wire logic dropped_stb
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ptr_step;
    entry_stb |-> wr_ptr == $past(wr_ptr) + 6'h1;
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("pointer did not step");
  property p_ptr_hold;
    !entry_stb |-> $stable(wr_ptr);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold)
    else $error("pointer moved without entry");
  property p_drop_mode;
    dropped_stb |-> $past(mode) == dtc_pkg::DTC_MODE_LOOP;
  endproperty
  a_drop_mode: assert property (p_drop_mode)
    else $error("drop outside loop mode");
  property p_cause;
    entry_stb |-> $past(main_bus.valid) || $past(copro_bus.valid) || $past(copro_bus.valid, 2);
  endproperty
  a_cause: assert property (p_cause)
    else $error("entry without bus event");
  property p_en;
    !$past(trace_enable) && !$past(trace_enable, 2) |-> !entry_stb;
  endproperty
  a_en: assert property (p_en)
    else $error("entry while disabled");
  property p_wrap_set;
    $rose(wrapped) |-> wr_ptr == 6'h0 && entry_stb;
  endproperty
  a_wrap_set: assert property (p_wrap_set)
    else $error("wrap flag set off boundary");
  property p_wrap_keep;
    wrapped |=> wrapped;
  endproperty
  a_wrap_keep: assert property (p_wrap_keep)
    else $error("wrap flag lost");
  property p_pc_cause;
    entry_stb && $past(mode) == dtc_pkg::DTC_MODE_PURE_PC
      && $past(mode, 2) == dtc_pkg::DTC_MODE_PURE_PC
      |-> $past(main_bus.opcode_exec) || $past(copro_bus.opcode_exec)
      || $past(copro_bus.opcode_exec, 2);
  endproperty
  a_pc_cause: assert property (p_pc_cause)
    else $error("pc entry without opcode");
endmodule
bind dtc_capture dtc_capture_checker dtc_capture_checker_i (.clk, .rst_n, .trace_enable,
  .mode, .main_bus, .copro_bus, .wr_ptr, .wrapped, .entry_stb, .dropped_stb);
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      $display("MISMATCH %s exp %h got %h", n, e, g); \
      num_errors++; \
    end \
  end
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic trace_enable = 1'b0;
  dtc_pkg::dtc_mode_t mode = dtc_pkg::DTC_MODE_NORMAL;
  dtc_pkg::dtc_src_t trace_src = dtc_pkg::DTC_SRC_BOTH;
  logic [1:0] trace_range_select = 2'h0;
  logic [23:0] comp_c_addr = 24'h001000;
  logic [23:0] comp_d_addr = 24'h001fff;
  logic [5:0] rd_idx = 6'h0;
  dtc_pkg::dtc_main_bus_t main_bus;
  dtc_pkg::dtc_copro_bus_t copro_bus;
  dtc_pkg::dtc_line_t rd_line;
  logic [5:0] wr_ptr;
  logic wrapped;
  logic entry_stb;
  logic dropped_stb;
  int num_errors = 0;
  int checks_done = 0;
  int drops = 0;
  logic [25:0] ev [9] = '{26'h00a0b0c, 26'h00a0b0c, 26'h10a0b0c, 26'h10a0b0c, 26'h20a0b0c,
    26'h20a0b0c, 26'h00a0b0c, 26'h00d0e0f, 26'h00a0b0c};
  int st [7] = '{0, 2, 3, 4, 5, 7, 8};
  logic [44:0] dm [6] = '{{24'h001100, 16'h0, 5'h00}, {24'h001100, 16'h0, 5'h01},
    {24'h001000, 16'h1234, 5'h0a}, {24'h001fff, 16'h0056, 5'h13},
    {24'h002000, 16'h0, 5'h0a}, {24'h000fff, 16'h0, 5'h0a}};
  logic [43:0] dc [4] = '{{24'h003000, 16'h7777, 4'h6}, {24'h003002, 16'h0, 4'hf},
    {24'h003002, 16'h0, 4'h0}, {24'h003001, 16'h0088, 4'ha}};
  always #20 clk = ~clk;
  always @(posedge clk)
    if (dropped_stb === 1'b1)
      drops++;
  dtc_capture dtc_capture_i (.clk, .rst_n, .trace_enable, .mode, .trace_src,
    .trace_range_select, .comp_c_addr, .comp_d_addr, .main_bus, .copro_bus, .rd_idx,
    .rd_line, .wr_ptr, .wrapped, .entry_stb, .dropped_stb);
  dtc_bus_model dtc_bus_model_i (.clk, .main_bus, .copro_bus);
  function automatic dtc_pkg::dtc_main_bus_t mb(logic [23:0] a, logic [15:0] d,
    logic [4:0] f, logic [3:0] x);
    return {1'b1, a, d, f, x, a};
  endfunction
  function automatic dtc_pkg::dtc_copro_bus_t cb(logic [23:0] a, logic [15:0] d,
    logic [3:0] f, logic [4:0] x);
    return {1'b1, a, d, f, x, a};
  endfunction
  task automatic settle;
    repeat (3) dtc_bus_model_i.send('0, '0);
    #1;
  endtask
  task automatic rd(input int i, input dtc_pkg::dtc_line_t e);
    @(posedge clk);
    rd_idx <= 6'(i);
    @(posedge clk);
    #1;
    `CHK("rd_line", e, rd_line)
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (2000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    trace_enable <= 1'b1;
    dtc_bus_model_i.send(mb(24'h123456, 16'h0, 5'h0, 4'h2), cb(24'h654321, 16'h0, 4'h0, 5'h0c));
    settle();
    rd(0, {24'h123456, 8'h00, 40'h0});
    rd(1, {24'h654321, 8'h84, 40'h0});
    mode <= dtc_pkg::DTC_MODE_LOOP;
    foreach (ev[i])
      dtc_bus_model_i.send(mb(ev[i][23:0], 16'h0, 5'h0, {ev[i][25:24], 2'h2}), '0);
    settle();
    `CHK("drops", 2, drops)
    foreach (st[i])
      rd(2 + i, {ev[st[i]][23:0], 4'h0, ev[st[i]][25:24], 2'h0, 40'h0});
    mode <= dtc_pkg::DTC_MODE_DETAIL;
    trace_src <= dtc_pkg::DTC_SRC_MAIN;
    trace_range_select <= 2'h3;
    foreach (dm[i])
      dtc_bus_model_i.send(mb(dm[i][44:21], dm[i][20:5], dm[i][4:0], 4'h0),
        cb(24'h00beef, 16'h0, 4'h0, 5'h01));
    settle();
    `CHK("wr_ptr", 6'h0b, wr_ptr)
    rd(9, {24'h001000, 8'h12, 16'h1234, 24'h00beef});
    rd(10, {24'h001fff, 8'h11, 16'h0056, 24'h00beef});
    trace_src <= dtc_pkg::DTC_SRC_COPRO;
    foreach (dc[i])
      dtc_bus_model_i.send(mb(24'h00cafe, 16'h0, 5'h0, 4'h0),
        cb(dc[i][43:20], dc[i][19:4], dc[i][3:0], 5'h01));
    settle();
    `CHK("wr_ptr", 6'h0d, wr_ptr)
    rd(11, {24'h003000, 8'h82, 16'h7777, 24'h00cafe});
    rd(12, {24'h003001, 8'h81, 16'h0088, 24'h00cafe});
    mode <= dtc_pkg::DTC_MODE_PURE_PC;
    trace_src <= dtc_pkg::DTC_SRC_BOTH;
    dtc_bus_model_i.send(mb(24'h004000, 16'h0, 5'h0, 4'h1), cb(24'h005000, 16'h0, 4'h0, 5'h02));
    dtc_bus_model_i.send(mb(24'h004004, 16'h0, 5'h0, 4'h2), '0);
    settle();
    rd(13, {24'h004000, 8'h00, 40'h0});
    rd(14, {24'h005000, 8'h80, 40'h0});
    mode <= dtc_pkg::DTC_MODE_NORMAL;
    repeat (48) dtc_bus_model_i.send(mb(24'h006000, 16'h0, 5'h0, 4'h6), '0);
    settle();
    `CHK("wrap", 7'h3f, {wrapped, wr_ptr})
    dtc_bus_model_i.send(mb(24'h006000, 16'h0, 5'h0, 4'h6), '0);
    settle();
    `CHK("wrap", 7'h40, {wrapped, wr_ptr})
    trace_enable <= 1'b0;
    dtc_bus_model_i.send(mb(24'h007000, 16'h0, 5'h0, 4'h6), '0);
    settle();
    `CHK("disabled", 7'h40, {wrapped, wr_ptr})
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("reset", 9'h000, {wrapped, wr_ptr, entry_stb, dropped_stb})
    end_of_test();
  end
endmodule
`default_nettype wire
